// ### rtl/opm_mode_ctrl.sv
// operating-mode state and per-mode defaults
`timescale 1ns/1ps
`include "opm_params.svh"
// Contract
// [RULE1] reset enters real-address mode
// [RULE2] 64-bit: address 64, operand 32 default
// [RULE3] honour overrides; extension prefix gives 64-bit
// [RULE4] 64-bit widens registers, adds extra registers
// [RULE5] 64-bit uses wide pointer, relative addressing
// [RULE6] code-segment attribute picks long submode
// [RULE7] 64-bit flat space, paging required
// [RULE8] compatibility limits access to 4 Gbytes
// [RULE9] compatibility prefixes toggle 16/32, segmentation
// [RULE10] compatibility uses long-mode system mechanisms
// [RULE11] software enables protected before long mode
// [RULE12] no real mode while long active
// [RULE13] real: 1 Mbyte, 16 default, no paging
// [RULE14] real mode runs at privilege 0
// [RULE15] protected: 4 Gbytes, segmentation, task switch
// [RULE16] paging off: virtual equals physical
// [RULE17] protected supports privilege 0 to 3
// [RULE18] virtual-machine: privilege 3, 1 Mbyte, 16-bit
// [RULE19] flag changes only by task/return load; code also clears it while long enabled or protected off
// [RULE20] pop-flags never changes the flag
// [RULE21] long enabled: ignore virtual-machine entry
// [RULE22] real address is selector shl 4 plus offset
// [RULE23] one state register drives every default
module opm_mode_ctrl
   import opm_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // control bits from privileged software
   input wire logic prot_enable,
   input wire logic paging_enable,
   input wire logic long_enable,
   input wire logic cs_long_attr,
   input wire logic cs_default_32,
   input wire logic [1:0] cs_privilege,
   // flag update sources
   input wire logic flags_load_task_state_segment,
   input wire logic interrupt_return_instruction,
   input wire logic pop_flags_instruction,
   input wire logic virtual_machine_flag_in,
   // per-instruction prefixes
   input wire logic operand_size_prefix,
   input wire logic address_size_prefix,
   input wire logic register_extension_prefix,
   // address formation
   input wire logic [15:0] seg_selector,
   input wire logic [15:0] eff_addr16,
   input wire logic [63:0] eff_addr,
   input wire logic [63:0] ip_next,
   input wire logic [31:0] rel_disp,
   // mode state
   output opm_pkg::opm_mode_t mode,
   output logic virtual_machine_flag,
   output logic long_active,
   // sizes
   output opm_pkg::opm_size_t addr_size,
   output opm_pkg::opm_size_t oper_size,
   // register resources
   output logic [6:0] gpr_width,
   output logic [4:0] gpr_count,
   output logic [4:0] vec_count,
   output logic [7:0] vec_width,
   output logic ext_regs_enable,
   output logic rel_addr_enable,
   // memory view
   output logic [63:0] addr_limit,
   output logic limit_fault,
   output logic seg_enable,
   output logic paging_active,
   output logic task_switch_enable,
   output logic long_sys_struct,
   output logic [63:0] phys_addr,
   output logic [63:0] wide_instruction_pointer,
   output logic [1:0] cur_privilege
);
   import opm_pkg::*;

   // ----------------------------------------
   // mode and flag state
   // ----------------------------------------
   opm_mode_t mode_q, mode_d;
   logic vm_q, vm_d;
   logic lma_q, lma_d;

   always_comb
   begin
      vm_d = vm_q;
      // [RULE19] only task or return load
      if (flags_load_task_state_segment || (interrupt_return_instruction && cur_privilege == `OPM_PL0))
      begin
         // [RULE21] ignored under long mode
         if (!long_enable)
            vm_d = virtual_machine_flag_in;
      end
      // [RULE20] pop-flags leaves flag
      if (pop_flags_instruction && !flags_load_task_state_segment && !interrupt_return_instruction)
         vm_d = vm_q;
      if (long_enable || !prot_enable)
         vm_d = 1'b0;
      // [RULE11] long needs protected paging
      lma_d = long_enable && prot_enable && paging_enable;
      // [RULE12] no real under long
      if (!prot_enable)
         mode_d = OPM_REAL;
      else if (lma_d)
      begin
         // [RULE6] segment attribute selects
         if (cs_long_attr)
            mode_d = OPM_LONG64;
         else
            mode_d = OPM_COMPAT;
      end
      else if (vm_d)
         mode_d = OPM_VM86;
      else if (paging_enable)
         mode_d = OPM_PROT_PG;
      else
         mode_d = OPM_PROT;
   end

   // [RULE1] reset to real mode
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         mode_q <= OPM_REAL;
         vm_q <= 1'b0;
         lma_q <= 1'b0;
      end
      else
      begin
         mode_q <= mode_d;
         vm_q <= vm_d;
         lma_q <= lma_d;
      end
   end

   // ----------------------------------------
   // derived defaults
   // ----------------------------------------
   logic [19:0] real_phys;

   // [RULE22] real translation
   opm_real_xlate #(
      .SEL_W(16),
      .OUT_W(`OPM_REAL_ADDR_W)
   ) u_xlate (
      .sel(seg_selector),
      .offset(eff_addr16),
      .phys(real_phys)
   );

   opm_size_t as_d, os_d;
   logic [6:0] gw_d;
   logic [4:0] gc_d, vc_d;
   logic ext_d, rel_d, seg_d, pg_d, ts_d, lss_d, lf_d;
   logic [63:0] lim_d, pa_d, ip_d;
   logic [1:0] pl_d;

   // [RULE23] all from mode register
   always_comb
   begin
      as_d = `OPM_SIZE_16;
      os_d = `OPM_SIZE_16;
      gw_d = `OPM_GPR_W_32;
      gc_d = `OPM_GPR_CNT_BASE;
      vc_d = `OPM_VEC_CNT_BASE;
      ext_d = 1'b0;
      rel_d = 1'b0;
      seg_d = 1'b1;
      pg_d = 1'b0;
      ts_d = 1'b0;
      lss_d = 1'b0;
      lim_d = `OPM_4G_LIMIT;
      pa_d = eff_addr;
      ip_d = {32'h0000_0000, ip_next[31:0]};
      pl_d = cs_privilege;
      unique case (mode_q)
         OPM_REAL:
         begin
            // [RULE13] real sizes, no paging
            os_d = operand_size_prefix ? `OPM_SIZE_32 : `OPM_SIZE_16;
            as_d = address_size_prefix ? `OPM_SIZE_32 : `OPM_SIZE_16;
            lim_d = `OPM_REAL_LIMIT;
            pa_d = {44'h0, real_phys};
            // [RULE14] privilege zero
            pl_d = `OPM_PL0;
         end
         OPM_VM86:
         begin
            // [RULE18] privilege 3, 1 Mbyte
            os_d = operand_size_prefix ? `OPM_SIZE_32 : `OPM_SIZE_16;
            as_d = address_size_prefix ? `OPM_SIZE_32 : `OPM_SIZE_16;
            lim_d = `OPM_REAL_LIMIT;
            pa_d = {44'h0, real_phys};
            pl_d = `OPM_PL3;
            pg_d = paging_enable;
         end
         OPM_PROT, OPM_PROT_PG:
         begin
            // [RULE15] 4 Gbytes, segments, tasks
            os_d = (cs_default_32 ^ operand_size_prefix) ? `OPM_SIZE_32 : `OPM_SIZE_16;
            as_d = (cs_default_32 ^ address_size_prefix) ? `OPM_SIZE_32 : `OPM_SIZE_16;
            ts_d = 1'b1;
            // [RULE16] paging flag only; address passes untranslated
            pg_d = (mode_q == OPM_PROT_PG);
            pa_d = {32'h0000_0000, eff_addr[31:0]};
            // [RULE17] levels 0 to 3
            pl_d = cs_privilege;
         end
         OPM_LONG64:
         begin
            // [RULE2] 64 address, 32 operand
            as_d = address_size_prefix ? `OPM_SIZE_32 : `OPM_SIZE_64;
            // [RULE3] overrides and extension prefix
            if (register_extension_prefix)
               os_d = `OPM_SIZE_64;
            else
               os_d = operand_size_prefix ? `OPM_SIZE_16 : `OPM_SIZE_32;
            // [RULE4] wide and extra registers
            gw_d = `OPM_GPR_W_64;
            gc_d = register_extension_prefix ? `OPM_GPR_CNT_EXT : `OPM_GPR_CNT_BASE;
            vc_d = register_extension_prefix ? `OPM_VEC_CNT_EXT : `OPM_VEC_CNT_BASE;
            ext_d = 1'b1;
            // [RULE5] wide pointer, relative data
            rel_d = 1'b1;
            ip_d = ip_next + {{32{rel_disp[31]}}, rel_disp};
            // [RULE7] flat, paging on
            seg_d = 1'b0;
            pg_d = 1'b1;
            lim_d = `OPM_FLAT_LIMIT;
            lss_d = 1'b1;
         end
         OPM_COMPAT:
         begin
            // [RULE9] toggled 16/32 sizes
            os_d = (cs_default_32 ^ operand_size_prefix) ? `OPM_SIZE_32 : `OPM_SIZE_16;
            as_d = (cs_default_32 ^ address_size_prefix) ? `OPM_SIZE_32 : `OPM_SIZE_16;
            // [RULE8] low 4 Gbytes
            lim_d = `OPM_4G_LIMIT;
            pa_d = {32'h0000_0000, eff_addr[31:0]};
            // [RULE10] long-mode mechanisms
            pg_d = 1'b1;
            lss_d = 1'b1;
         end
         default:
         begin
            pl_d = `OPM_PL0;
         end
      endcase
      lf_d = (eff_addr > lim_d);
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         addr_size <= `OPM_SIZE_16;
         oper_size <= `OPM_SIZE_16;
         gpr_width <= `OPM_GPR_W_32;
         gpr_count <= `OPM_GPR_CNT_BASE;
         vec_count <= `OPM_VEC_CNT_BASE;
         vec_width <= `OPM_VEC_W;
         ext_regs_enable <= 1'b0;
         rel_addr_enable <= 1'b0;
         addr_limit <= `OPM_REAL_LIMIT;
         limit_fault <= 1'b0;
         seg_enable <= 1'b1;
         paging_active <= 1'b0;
         task_switch_enable <= 1'b0;
         long_sys_struct <= 1'b0;
         phys_addr <= 64'h0;
         wide_instruction_pointer <= 64'h0;
         cur_privilege <= `OPM_PL0;
      end
      else
      begin
         addr_size <= as_d;
         oper_size <= os_d;
         gpr_width <= gw_d;
         gpr_count <= gc_d;
         vec_count <= vc_d;
         vec_width <= `OPM_VEC_W;
         ext_regs_enable <= ext_d;
         rel_addr_enable <= rel_d;
         addr_limit <= lim_d;
         limit_fault <= lf_d;
         seg_enable <= seg_d;
         paging_active <= pg_d;
         task_switch_enable <= ts_d;
         long_sys_struct <= lss_d;
         phys_addr <= pa_d;
         wide_instruction_pointer <= ip_d;
         cur_privilege <= pl_d;
      end
   end

   assign mode = mode_q;
   assign virtual_machine_flag = vm_q;
   assign long_active = lma_q;
endmodule

// ### rtl/opm_params.svh
// constants for the operating-mode control block
`ifndef OPM_PARAMS_SVH
`define OPM_PARAMS_SVH
`define OPM_SEG_SHIFT 4
`define OPM_REAL_ADDR_W 20
`define OPM_REAL_LIMIT 64'h0000_0000_000f_ffff
`define OPM_4G_LIMIT 64'h0000_0000_ffff_ffff
`define OPM_FLAT_LIMIT 64'hffff_ffff_ffff_ffff
`define OPM_SIZE_16 2'h0
`define OPM_SIZE_32 2'h1
`define OPM_SIZE_64 2'h2
`define OPM_PL0 2'h0
`define OPM_PL3 2'h3
`define OPM_GPR_W_32 7'h20
`define OPM_GPR_W_64 7'h40
`define OPM_GPR_CNT_BASE 5'h08
`define OPM_GPR_CNT_EXT 5'h10
`define OPM_VEC_CNT_BASE 5'h08
`define OPM_VEC_CNT_EXT 5'h10
`define OPM_VEC_W 8'h80
`endif

// ### rtl/opm_pkg.sv
// types for the operating-mode control block
package opm_pkg;
   typedef enum logic [5:0] {
      OPM_REAL = 6'h01,
      OPM_PROT = 6'h02,
      OPM_VM86 = 6'h04,
      OPM_LONG64 = 6'h08,
      OPM_COMPAT = 6'h10,
      OPM_PROT_PG = 6'h20
   } opm_mode_t;
   typedef logic [1:0] opm_size_t;
endpackage

// ### rtl/opm_real_xlate.sv
// real-style segment plus offset address former
`timescale 1ns/1ps
`include "opm_params.svh"
module opm_real_xlate #(
   parameter int SEL_W = 16,
   parameter int OUT_W = 20
) (
   // inputs
   input wire logic [SEL_W-1:0] sel,
   input wire logic [SEL_W-1:0] offset,
   // result
   output logic [OUT_W-1:0] phys
);
   // refuse widths the shift cannot serve
   if (OUT_W != SEL_W + `OPM_SEG_SHIFT)
   begin
      $error("opm_real_xlate: width mismatch");
   end
   // [RULE22] shift and add
   always_comb
   begin
      phys = OUT_W'({sel, 4'h0}) + OUT_W'(offset);
   end
endmodule

// ### verif/opm_mode_chk.sv
// assertions for the operating-mode control block
`timescale 1ns/1ps
`include "opm_params.svh"
module opm_mode_chk
   import opm_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // controls and flag sources
   input wire logic prot_enable,
   input wire logic long_enable,
   input wire logic flags_load_task_state_segment,
   input wire logic interrupt_return_instruction,
   input wire logic pop_flags_instruction,
   input wire logic operand_size_prefix,
   input wire logic address_size_prefix,
   input wire logic register_extension_prefix,
   // outputs watched
   input wire opm_pkg::opm_mode_t mode,
   input wire logic virtual_machine_flag,
   input wire opm_pkg::opm_size_t addr_size,
   input wire opm_pkg::opm_size_t oper_size,
   input wire logic [63:0] addr_limit,
   input wire logic [1:0] cur_privilege
);
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_reset_real;
      disable iff (1'b0) !rst_b |=> mode == OPM_REAL;
   endproperty
   a_reset_real: assert property (p_reset_real) else $error("mode not real after reset");
   property p_sz64;
      mode == OPM_LONG64 && !address_size_prefix |=> addr_size == `OPM_SIZE_64;
   endproperty
   a_sz64: assert property (p_sz64) else $error("address size not 64");
   property p_rex;
      mode == OPM_LONG64 && register_extension_prefix && !operand_size_prefix |=> oper_size == `OPM_SIZE_64;
   endproperty
   a_rex: assert property (p_rex) else $error("extension prefix size wrong");
   property p_real_pl0;
      mode == OPM_REAL |=> cur_privilege == `OPM_PL0 && addr_limit == `OPM_REAL_LIMIT;
   endproperty
   a_real_pl0: assert property (p_real_pl0) else $error("real mode privilege or limit wrong");
   property p_vm_pl3;
      mode == OPM_VM86 |=> cur_privilege == `OPM_PL3;
   endproperty
   a_vm_pl3: assert property (p_vm_pl3) else $error("virtual machine privilege wrong");
   property p_compat_lim;
      mode == OPM_COMPAT |=> addr_limit == `OPM_4G_LIMIT;
   endproperty
   a_compat_lim: assert property (p_compat_lim) else $error("compat limit wrong");
   property p_long_flat;
      mode == OPM_LONG64 |=> addr_limit == `OPM_FLAT_LIMIT;
   endproperty
   a_long_flat: assert property (p_long_flat) else $error("long flat limit wrong");
   property p_pop_flags_instruction;
      pop_flags_instruction && !flags_load_task_state_segment && !interrupt_return_instruction
         && prot_enable && !long_enable |=> $stable(virtual_machine_flag);
   endproperty
   a_pop_flags_instruction: assert property (p_pop_flags_instruction) else $error("pop flags changed flag");
   property p_vm_long;
      long_enable |=> !virtual_machine_flag;
   endproperty
   a_vm_long: assert property (p_vm_long) else $error("flag set while long enabled");
   c_vm: cover property (mode == OPM_VM86);
   c_long64: cover property (mode == OPM_LONG64);
   c_compat: cover property (mode == OPM_COMPAT);
endmodule
bind opm_mode_ctrl opm_mode_chk i_opm_mode_chk (.clk_sys, .rst_b, .prot_enable, .long_enable,
   .flags_load_task_state_segment, .interrupt_return_instruction, .pop_flags_instruction,
   .operand_size_prefix, .address_size_prefix, .register_extension_prefix, .mode,
   .virtual_machine_flag, .addr_size, .oper_size, .addr_limit, .cur_privilege);

// ### verif/opm_sw_model.sv
// model of privileged software setting the mode controls
`timescale 1ns/1ps
module opm_sw_model (
   // clock and requested state
   input wire logic clk_sys,
   input wire logic want_prot,
   input wire logic want_paging,
   input wire logic want_long,
   // control levels
   output logic prot_enable = 1'b0,
   output logic paging_enable = 1'b0,
   output logic long_enable = 1'b0
);
   // -----------------
   // control sequencing
   // -----------------
   always @(posedge clk_sys)
   begin
      prot_enable <= want_prot;
      paging_enable <= want_paging;
      long_enable <= want_long && prot_enable;
   end
endmodule

// ### verif/tb_opm_mode_ctrl.sv
// self-checking bench for the operating-mode control block
`timescale 1ns/1ps
`include "opm_params.svh"
module tb_opm_mode_ctrl;
   import opm_pkg::*;
   typedef struct packed {logic [6:0] ctl; logic [5:0] m; logic [1:0] a; logic [1:0] o;} opm_row_t;
   logic clk_sys;
   logic rst_b = 1'b0;
   logic want_prot = 1'b0, want_paging = 1'b0, want_long = 1'b0, cs_long_attr = 1'b0, cs_default_32 = 1'b0;
   logic flg_tss = 1'b0, flg_interrupt_return_instruction = 1'b0, flg_pop_flags_instruction = 1'b0, vm_in = 1'b0, opp = 1'b0, rexp = 1'b0;
   logic asp = 1'b0;
   logic [63:0] ea = 64'h0000_0000_0000_0000;
   logic [1:0] cs_privilege = 2'h0;
   logic [15:0] seg = 16'h1234, off = 16'h0005;
   logic [63:0] ip = 64'h0000_0000_0000_1000;
   logic [31:0] disp = 32'hffff_fff0;
   logic prot_enable, paging_enable, long_enable, vm_flag, long_active;
   opm_mode_t mode;
   opm_size_t addr_size, oper_size;
   logic [6:0] gpr_width;
   logic [4:0] gpr_count, vec_count;
   logic [7:0] vec_width;
   logic ext_regs_enable, rel_addr_enable, limit_fault, seg_enable, paging_active;
   logic task_switch_enable, long_sys_struct;
   logic [63:0] addr_limit, phys_addr, wip;
   logic [1:0] cur_privilege;
   int errors = 0, compares = 0;
   opm_row_t rows [12] = '{'{7'h00, 6'h01, 2'h0, 2'h0}, '{7'h02, 6'h01, 2'h0, 2'h1},
      '{7'h40, 6'h02, 2'h0, 2'h0}, '{7'h44, 6'h02, 2'h1, 2'h1}, '{7'h64, 6'h20, 2'h1, 2'h1},
      '{7'h5c, 6'h02, 2'h1, 2'h1}, '{7'h78, 6'h08, 2'h2, 2'h1}, '{7'h79, 6'h08, 2'h2, 2'h2},
      '{7'h7a, 6'h08, 2'h2, 2'h0}, '{7'h74, 6'h10, 2'h1, 2'h1}, '{7'h70, 6'h10, 2'h0, 2'h0},
      '{7'h76, 6'h10, 2'h1, 2'h0}};
   // -----------
   // environment
   // -----------
   opm_sw_model i_opm_sw_model (.clk_sys, .want_prot, .want_paging, .want_long, .prot_enable,
      .paging_enable, .long_enable);
   opm_mode_ctrl i_opm_mode_ctrl (.clk_sys, .rst_b, .prot_enable, .paging_enable, .long_enable,
      .cs_long_attr, .cs_default_32, .cs_privilege, .flags_load_task_state_segment(flg_tss),
      .interrupt_return_instruction(flg_interrupt_return_instruction), .pop_flags_instruction(flg_pop_flags_instruction),
      .virtual_machine_flag_in(vm_in), .operand_size_prefix(opp), .address_size_prefix(asp),
      .register_extension_prefix(rexp), .seg_selector(seg), .eff_addr16(off), .eff_addr(ea),
      .ip_next(ip), .rel_disp(disp), .mode, .virtual_machine_flag(vm_flag), .long_active, .addr_size,
      .oper_size, .gpr_width, .gpr_count, .vec_count, .vec_width, .ext_regs_enable,
      .rel_addr_enable, .addr_limit, .limit_fault, .seg_enable, .paging_active,
      .task_switch_enable, .long_sys_struct, .phys_addr, .wide_instruction_pointer(wip),
      .cur_privilege);
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic setc(input logic [6:0] c);
      @(posedge clk_sys);
      {want_prot, want_paging, want_long, cs_long_attr, cs_default_32, opp, rexp} <= c;
      repeat (5) @(posedge clk_sys);
      #1;
   endtask
   task automatic pulse(input int k, input logic v);
      repeat (3) @(posedge clk_sys);
      vm_in <= v;
      flg_tss <= (k == 0);
      flg_interrupt_return_instruction <= (k == 1);
      flg_pop_flags_instruction <= (k == 2);
      @(posedge clk_sys);
      {flg_tss, flg_interrupt_return_instruction, flg_pop_flags_instruction} <= 3'h0;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic complete_run;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (1000) @(posedge clk_sys);
      errors++;
      complete_run;
   end
   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      #1;
      chk(mode, OPM_REAL);
      chk(cur_privilege, `OPM_PL0);
      chk(addr_limit, `OPM_REAL_LIMIT);
      foreach (rows[i])
      begin
         setc(rows[i].ctl);
         chk(mode, rows[i].m);
         chk(addr_size, rows[i].a);
         chk(oper_size, rows[i].o);
      end
      @(posedge clk_sys);
      asp <= 1'b1;
      ea <= 64'h0000_0001_0000_0000;
      setc(7'h74);
      chk(addr_size, `OPM_SIZE_16);
      chk(limit_fault, 1'b1);
      chk(phys_addr, 64'h0000_0000_0000_0000);
      chk(seg_enable, 1'b1);
      chk(paging_active, 1'b1);
      chk(long_sys_struct, 1'b1);
      setc(7'h79);
      chk(addr_size, `OPM_SIZE_32);
      chk(oper_size, `OPM_SIZE_64);
      chk(gpr_count, `OPM_GPR_CNT_EXT);
      chk(vec_count, `OPM_VEC_CNT_EXT);
      chk(vec_width, `OPM_VEC_W);
      chk(ext_regs_enable, 1'b1);
      chk(rel_addr_enable, 1'b1);
      chk(limit_fault, 1'b0);
      chk(seg_enable, 1'b0);
      chk(paging_active, 1'b1);
      chk(phys_addr, 64'h0000_0001_0000_0000);
      @(posedge clk_sys);
      cs_privilege <= 2'h2;
      asp <= 1'b0;
      ea <= 64'h0000_0000_89ab_cdef;
      setc(7'h44);
      chk(cur_privilege, 2'h2);
      chk(addr_limit, `OPM_4G_LIMIT);
      chk(task_switch_enable, 1'b1);
      chk(paging_active, 1'b0);
      chk(phys_addr, 64'h0000_0000_89ab_cdef);
      @(posedge clk_sys) cs_privilege <= 2'h0;
      pulse(1, 1'b1);
      chk(vm_flag, 1'b1);
      chk(mode, OPM_VM86);
      chk(cur_privilege, `OPM_PL3);
      pulse(2, 1'b0);
      chk(vm_flag, 1'b1);
      pulse(1, 1'b0);
      chk(vm_flag, 1'b1);
      pulse(0, 1'b0);
      chk(vm_flag, 1'b0);
      setc(7'h78);
      pulse(0, 1'b1);
      chk(vm_flag, 1'b0);
      chk(long_active, 1'b1);
      chk(wip, 64'h0000_0000_0000_0ff0);
      chk(gpr_width, `OPM_GPR_W_64);
      setc(7'h00);
      chk(phys_addr, 64'h0000_0000_0001_2345);
      chk(addr_limit, `OPM_REAL_LIMIT);
      chk(limit_fault, 1'b1);
      chk(paging_active, 1'b0);
      setc(7'h64);
      chk(mode, OPM_PROT_PG);
      chk(paging_active, 1'b1);
      setc(7'h78);
      @(posedge clk_sys) rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(mode, OPM_REAL);
      chk(addr_size, `OPM_SIZE_16);
      chk(long_active, 1'b0);
      chk(cur_privilege, `OPM_PL0);
      @(posedge clk_sys) rst_b <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(mode, OPM_LONG64);
      chk(long_active, 1'b1);
      complete_run;
   end
endmodule
